/* hdl/slb_bist.sv */
// deserializer-side at-speed self test of the serial link
// Functional notes
// (R1) select pins choose external or internal test clock
// (R2) code 00 needs external clock at serializer
// (R3) entering test sends back-channel test command
// (R4) serializer then streams its prbs pattern
// (R5) system waits for lock before reading results
// (R6) result high when good, low half-cycle per fail
// (R7) consecutive fails toggle result each half-cycle
// (R8) accumulated error count kept during test
// (R9) serializer gpio0 flags control-channel errors
// (R10) window opens lock and enable, closes on enable
// (R11) local prbs copy checks each received payload after the first
`include "slb_defines.svh"

module slb_bist
    import slb_pkg::*;
#(
    parameter int PAYLOAD_W = 16,   // payload width in bits
    parameter int CNT_W     = 16    // error counter width
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 power_down_bar,   // low holds the block idle
    input  wire logic                 test_run_enable,  // pin, window width
    input  wire logic [1:0]           osc_sel,          // pin, test clock select
    input  wire logic                 link_locked,      // from the lock detector
    input  wire logic                 rx_valid,         // a payload arrived
    input  wire logic [PAYLOAD_W-1:0] rx_payload,       // the received payload
    input  wire logic                 cc_err_in,        // control-channel error pin of the far end
    output logic                      cmd_valid,        // back-channel command strobe
    output logic [7:0]                cmd_data,         // back-channel command word
    output logic                      osc_bypass,       // external clock is the test clock
    output logic [1:0]                osc_rate,         // internal rate: 1=50, 2=25, 3=12.5 MHz
    output logic                      test_result,      // pass flag pin level
    output logic [CNT_W-1:0]          err_count,        // accumulated payload errors
    output logic [CNT_W-1:0]          cc_err_count,     // accumulated control-channel errors
    output logic                      test_active       // window is open
);

    // =========================================================================
    // elaboration checks
    // =========================================================================
    if (PAYLOAD_W != 16) begin : g_bad_w
        $error("prbs taps assume a 16-bit payload");
    end
    if (CNT_W < 2) begin : g_bad_c
        $error("error counter too narrow");
    end

    // =========================================================================
    // pin synchronisers
    // =========================================================================
    logic [1:0] en_sq;   // enable pin, two stages
    logic [1:0] pd_sq;   // power-down pin, two stages
    logic [1:0] cc_sq;   // control-channel error pin
    logic [1:0] sel0_sq; // select bit 0
    logic [1:0] sel1_sq; // select bit 1

    // logic reads only the second stage of each chain, never a raw pin
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            en_sq   <= 2'h0;
            pd_sq   <= 2'h0;
            cc_sq   <= 2'h0;
            sel0_sq <= 2'h0;
            sel1_sq <= 2'h0;
        end else begin
            en_sq   <= {en_sq[0], test_run_enable};
            pd_sq   <= {pd_sq[0], power_down_bar};
            cc_sq   <= {cc_sq[0], cc_err_in};
            sel0_sq <= {sel0_sq[0], osc_sel[0]};
            sel1_sq <= {sel1_sq[0], osc_sel[1]};
        end
    end

    wire logic       en_s  = en_sq[1];
    wire logic       pd_s  = pd_sq[1];
    wire logic       cc_s  = cc_sq[1];
    wire logic [1:0] sel_s = {sel1_sq[1], sel0_sq[1]};

    // =========================================================================
    // prbs step, used by the checker for every payload
    // =========================================================================
    function automatic logic [15:0] prbs_next(input logic [15:0] s);
        logic [15:0] r;
        integer      i;
        r = s;
        for (i = 0; i < 16; i++) begin
            r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
        end
        return r;
    endfunction

    // =========================================================================
    // sequencer and checker state
    // =========================================================================
    slb_state_t           st_q, st_d;
    logic [15:0]          prbs_q, prbs_d;     // expected next payload
    logic                 sync_q, sync_d;     // checker aligned to stream
    logic [CNT_W-1:0]     err_q, err_d;
    logic [CNT_W-1:0]     cce_q, cce_d;
    logic                 fail_q, fail_d;     // payload just failed
    logic                 cmdv_q, cmdv_d;
    logic [7:0]           cmdd_q, cmdd_d;
    logic                 bypass_q, bypass_d;
    logic [1:0]           rate_q, rate_d;
    logic                 cc_prev_q;

    // next-state logic for the whole test
    always_comb begin
        st_d     = st_q;
        prbs_d   = prbs_q;
        sync_d   = sync_q;
        err_d    = err_q;
        cce_d    = cce_q;
        fail_d   = 1'b0;
        cmdv_d   = 1'b0;
        cmdd_d   = cmdd_q;
        bypass_d = bypass_q;
        rate_d   = rate_q;
        case (st_q)
            SLB_IDLE: begin
                if (en_s && pd_s) begin
                    // latch clock choice for the whole test
                    bypass_d = (sel_s == `SLB_OSC_EXT);                 // see (R1) (R2)
                    rate_d   = sel_s;                                    // see (R1)
                    err_d    = CNT_W'(`SLB_ERR_RST);
                    cce_d    = CNT_W'(`SLB_ERR_RST);
                    sync_d   = 1'b0;
                    st_d     = SLB_CMD;
                end
            end
            SLB_CMD: begin
                // one command word tells the serializer to start its pattern
                cmdv_d = 1'b1;                                           // see (R3) (R4)
                cmdd_d = `SLB_CMD_TEST_ON;
                st_d   = SLB_WAIT;
            end
            SLB_WAIT: begin
                // lock may take ms; the sequencer waits here for it
                if (!en_s) begin
                    st_d = SLB_IDLE;
                end else if (link_locked) begin                          // see (R5) (R10)
                    st_d = SLB_RUN;
                end
            end
            SLB_RUN: begin
                if (!en_s) begin
                    // window closed: later errors are not counted
                    cmdv_d = 1'b1;                                       // see (R10)
                    cmdd_d = `SLB_CMD_TEST_OFF;
                    st_d   = SLB_IDLE;
                end else begin
                    if (rx_valid) begin
                        if (!sync_q) begin
                            // first payload after lock seeds the local copy
                            prbs_d = prbs_next(rx_payload);              // see (R11)
                            sync_d = 1'b1;
                        end else begin
                            prbs_d = prbs_next(prbs_q);
                            if (rx_payload != prbs_q) begin              // see (R11)
                                fail_d = 1'b1;
                                if (err_q != {CNT_W{1'b1}}) begin        // saturate
                                    err_d = err_q + 1'b1;                // see (R8)
                                end
                            end
                        end
                    end
                    // count rising edges of the far end's error pin
                    if (cc_s && !cc_prev_q && cce_q != {CNT_W{1'b1}}) begin
                        cce_d = cce_q + 1'b1;                            // see (R9)
                    end
                end
            end
            default: st_d = SLB_IDLE;
        endcase
        // power-down wins over every state; a command set in this same cycle still goes out
        if (!pd_s) begin
            st_d = SLB_IDLE;
        end
    end

    // registers of the sequencer and checker
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q      <= SLB_IDLE;
            prbs_q    <= `SLB_PRBS_SEED;
            sync_q    <= 1'b0;
            err_q     <= CNT_W'(`SLB_ERR_RST);
            cce_q     <= CNT_W'(`SLB_ERR_RST);
            fail_q    <= 1'b0;
            cmdv_q    <= 1'b0;
            cmdd_q    <= 8'h00;
            bypass_q  <= 1'b0;
            rate_q    <= 2'h0;
            cc_prev_q <= 1'b0;
        end else begin
            st_q      <= st_d;
            prbs_q    <= prbs_d;
            sync_q    <= sync_d;
            err_q     <= err_d;
            cce_q     <= cce_d;
            fail_q    <= fail_d;
            cmdv_q    <= cmdv_d;
            cmdd_q    <= cmdd_d;
            bypass_q  <= bypass_d;
            rate_q    <= rate_d;
            cc_prev_q <= cc_s;
        end
    end

    // =========================================================================
    // result flag: low in the second half of a failing cycle
    // =========================================================================
    // a falling-edge and a rising-edge toggle register both follow the fail flag;
    // they differ only from the falling edge to the next rising edge, so the pin
    // drops for half a cycle per fail and back-to-back fails toggle it each half
    // cycle, without the clock itself entering the data path
    logic res_p_q, res_p_d;   // toggles on the rising edge after a fail cycle
    logic res_n_q, res_n_d;   // toggles on the falling edge of a fail cycle

    // next values of both toggle registers
    always_comb begin
        res_p_d = res_p_q ^ fail_q;                                      // see (R6) (R7)
        res_n_d = res_n_q ^ fail_q;                                      // see (R6) (R7)
    end

    // rising-edge half of the pulse pair
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            res_p_q <= 1'b0;
        end else begin
            res_p_q <= res_p_d;
        end
    end

    // falling-edge half of the pulse pair
    always_ff @(negedge core_clk or posedge rst) begin
        if (rst) begin
            res_n_q <= 1'b0;
        end else begin
            res_n_q <= res_n_d;
        end
    end

    // stays high for good payloads and outside the window, except just after a payload fails in the cycle power-down leaves SLB_RUN
    assign test_result  = ~(res_p_q ^ res_n_q);                          // see (R6) (R7)
    assign err_count    = err_q;
    assign cc_err_count = cce_q;
    assign cmd_valid    = cmdv_q;
    assign cmd_data     = cmdd_q;
    assign osc_bypass   = bypass_q;
    assign osc_rate     = rate_q;
    assign test_active  = (st_q == SLB_RUN);

endmodule // slb_bist

/* hdl/slb_defines.svh */
// select codes, command words, prbs seed and reset values of the link self-test block
`ifndef SLB_DEFINES_SVH
`define SLB_DEFINES_SVH

// oscillator select codes on the two select pins
`define SLB_OSC_EXT        2'h0
`define SLB_OSC_50         2'h1
`define SLB_OSC_25         2'h2
`define SLB_OSC_12P5       2'h3

// back-channel command words that put the far serializer into and out of its self test
`define SLB_CMD_TEST_ON    8'hA5
`define SLB_CMD_TEST_OFF   8'h5A

// prbs seed, shared by both ends of the pattern
`define SLB_PRBS_SEED      16'hACE1

// error counter reset value
`define SLB_ERR_RST        16'h0000

`endif

/* hdl/slb_pkg.sv */
// types shared by the link self-test block
package slb_pkg;
    // test sequencer states, one-hot
    typedef enum logic [3:0] {
        SLB_IDLE = 4'b0001,
        SLB_CMD  = 4'b0010,
        SLB_WAIT = 4'b0100,
        SLB_RUN  = 4'b1000
    } slb_state_t;
endpackage

/* test/slb_bist_properties.sv */
// concurrent checks on the ports of the link self-test block
module slb_bist_properties #(
    parameter int CNT_W = 16
) (
    input logic             core_clk,
    input logic             rst,
    input logic             link_locked,
    input logic             rx_valid,
    input logic             cmd_valid,
    input logic             osc_bypass,
    input logic [1:0]       osc_rate,
    input logic             test_result,
    input logic [CNT_W-1:0] err_count,
    input logic [CNT_W-1:0] cc_err_count,
    input logic             test_active
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====
    // single clock domain, reset disables every check
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_cmd_pulse; cmd_valid |=> !cmd_valid; endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command strobe longer than one cycle");
    property p_bypass; osc_bypass |-> osc_rate == 2'h0; endproperty
    a_bypass: assert property (p_bypass) else $error("bypass without external code");
    property p_on_lock; $rose(test_active) |-> $past(link_locked); endproperty
    a_on_lock: assert property (p_on_lock) else $error("window opened without lock");
    // the error count moves only by one, and only after a payload
    property p_err_step; err_count != $past(err_count) && err_count != 0
        |-> $past(rx_valid) && err_count == $past(err_count) + 1'b1; endproperty
    a_err_step: assert property (p_err_step) else $error("error count step wrong");
    // two closed cycles in a row: late errors must not count
    property p_excl; !$past(test_active) && !$past(test_active, 2) && err_count != 0
        |-> $stable(err_count); endproperty
    a_excl: assert property (p_excl) else $error("error counted outside window");
    property p_fail_low; err_count != $past(err_count) && err_count != 0 |-> !test_result; endproperty
    a_fail_low: assert property (p_fail_low) else $error("no low half cycle for fail");
    // the first half of every cycle shows a high flag; only the second half may drop
    property p_res_half; @(negedge core_clk) test_result; endproperty
    a_res_half: assert property (p_res_half) else $error("flag low in first half");
    property p_low_cause; !test_result |-> err_count == $past(err_count) + 1'b1; endproperty
    a_low_cause: assert property (p_low_cause) else $error("low flag without a fail");
    property p_cc; cc_err_count != $past(cc_err_count) && cc_err_count != 0
        |-> cc_err_count == $past(cc_err_count) + 1'b1; endproperty
    a_cc: assert property (p_cc) else $error("control error count step wrong");
    c_fail: cover property (!test_result);
    c_run: cover property ($rose(test_active));
    c_cc: cover property (cc_err_count == 2);
endmodule // slb_bist_properties
bind slb_bist slb_bist_properties #(.CNT_W(CNT_W)) u_props (
    .core_clk(core_clk), .rst(rst), .link_locked(link_locked), .rx_valid(rx_valid),
    .cmd_valid(cmd_valid), .osc_bypass(osc_bypass), .osc_rate(osc_rate), .test_result(test_result),
    .err_count(err_count), .cc_err_count(cc_err_count), .test_active(test_active));

/* test/slb_ser_model.sv */
// behavioural far-end serializer answering test commands with a pattern
`include "slb_defines.svh"
module slb_ser_model #(parameter int LOCK_DLY = 8) (
    input  logic        core_clk,
    input  logic        rst,
    input  logic        cmd_valid,
    input  logic [7:0]  cmd_data,
    input  logic        inj,
    output logic        link_locked,
    output logic        rx_valid,
    output logic [15:0] rx_payload
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        on_q;
    int          cnt;
    logic [15:0] s_q;
    // sixteen shifts of the pattern register per payload
    function automatic logic [15:0] nxt(input logic [15:0] v);
        for (int i = 0; i < 16; i++) v = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
        return v;
    endfunction
    // =====
    // lock after a delay, then one payload every second cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {on_q, link_locked, rx_valid, cnt, rx_payload} <= '0;
            s_q <= `SLB_PRBS_SEED;
        end else begin
            rx_valid   <= 1'b0;
            rx_payload <= ~rx_payload; // idle lines never hold the last word
            if (cmd_valid) begin
                on_q        <= (cmd_data == `SLB_CMD_TEST_ON);
                cnt         <= 0;
                link_locked <= 1'b0;
            end else if (on_q) begin
                cnt <= cnt + 1;
                if (cnt == LOCK_DLY) link_locked <= 1'b1;
                if (cnt > LOCK_DLY && cnt[0]) begin
                    rx_valid   <= 1'b1;
                    rx_payload <= s_q ^ {15'h0, inj}; // corrupt only on request
                    s_q        <= nxt(s_q);
                end
            end
        end
    end
endmodule // slb_ser_model

/* test/tb.sv */
// self-checking bench for the link self-test block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0, rst = 1'b1, pwr_n = 1'b1, en = 1'b0, cc = 1'b0, inj = 1'b0;
    logic [1:0]  sel = 2'h0, rate;
    logic        lk, rv, cv, byp, res, act;
    logic [15:0] rp, ec, cce;
    logic [7:0]  cd;
    int          err_count = 0, total_checks = 0, cyc = 0, lows = 0;
    slb_bist dut (.core_clk(core_clk), .rst(rst), .power_down_bar(pwr_n), .test_run_enable(en),
        .osc_sel(sel), .link_locked(lk), .rx_valid(rv), .rx_payload(rp), .cc_err_in(cc),
        .cmd_valid(cv), .cmd_data(cd), .osc_bypass(byp), .osc_rate(rate), .test_result(res),
        .err_count(ec), .cc_err_count(cce), .test_active(act));
    // the far end keeps lock after an aborted start, so lock must come later than
    // the next start's command, or a stale lock would open that window at once
    slb_ser_model #(.LOCK_DLY(20)) u_ser (.core_clk(core_clk), .rst(rst), .cmd_valid(cv), .cmd_data(cd),
        .inj(inj), .link_locked(lk), .rx_valid(rv), .rx_payload(rp));
    initial forever #12.5 core_clk = ~core_clk;
    // =====
    // hang guard, and a count of low half cycles while the window is open
    always @(posedge core_clk) if (++cyc > 5000) begin err_count++; report_and_stop(); end
    always @(negedge core_clk) #1 if (act && res === 1'b0) lows++;
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wait_cmd(input logic [7:0] c);
        int i = 0;
        do @(negedge core_clk); while (cv !== 1'b1 && ++i < 20);
        chk({cv, cd}, {1'b1, c});
    endtask
    task automatic wait_act(input logic b);
        int i = 0;
        do @(negedge core_clk); while (act !== b && ++i < 100);
        chk(act, b);
    endtask
    task automatic start(input logic [1:0] k);
        @(posedge core_clk);
        sel <= k;
        en  <= 1'b1;
        wait_cmd(8'hA5);
    endtask
    task automatic stop;
        @(posedge core_clk);
        en <= 1'b0;
    endtask
    // =====
    // every select code, each start aborted while waiting for lock
    task automatic t_osc;
        for (int k = 0; k < 4; k++) begin
            start(k[1:0]);
            chk({byp, rate}, {k == 0, k[1:0]});
            stop();
            repeat (6) begin @(negedge core_clk); chk({cv, act}, 2'h0); end
        end
    endtask
    task automatic t_good;
        start(2'h1);
        wait_act(1'b1);
        lows = 0;
        tick(40);
        @(negedge core_clk);
        chk(ec, 16'h0);
        chk(16'(lows), 16'h0);
        stop();
        wait_cmd(8'h5A);
        wait_act(1'b0);
    endtask
    // one lone fail, three back to back, two control-channel errors
    task automatic t_err;
        start(2'h2);
        wait_act(1'b1);
        tick(6);
        lows = 0;
        inj <= 1'b1;
        tick(2);
        inj <= 1'b0;
        tick(6);
        inj <= 1'b1;
        tick(6);
        inj <= 1'b0;
        repeat (2) begin cc <= 1'b1; tick(4); cc <= 1'b0; tick(5); end
        @(negedge core_clk);
        chk(ec, 16'h4);
        chk(16'(lows), 16'h4);
        chk(cce, 16'h2);
        stop();
        wait_cmd(8'h5A);
        wait_act(1'b0);
        tick(10);
        chk(ec, 16'h4);
    endtask
    task automatic t_pd;
        start(2'h3);
        wait_act(1'b1);
        @(posedge core_clk);
        pwr_n <= 1'b0;
        wait_act(1'b0);
        // window closed by power-down while the far end still streams: bad payloads
        // arriving now must not reach the count
        @(posedge core_clk);
        inj <= 1'b1;
        tick(6);
        inj <= 1'b0;
        @(negedge core_clk);
        chk(ec, 16'h0);
        stop();
        pwr_n <= 1'b1;
        tick(4);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        tick(4);
        rst <= 1'b0;
        @(negedge core_clk);
        chk({res, act}, 2'h2);
        t_osc();
        t_good();
        t_err();
        t_pd();
        report_and_stop();
    end
endmodule // tb
